/* wit_watchdog_interval_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1: both mode bits set runs watchdog counting
// RQ2: software rewrites counter before it overflows
// RQ3: watchdog overflow drives output low 128 clocks
// RQ4: reset enable starts chip reset simultaneously
// RQ5: reset kind bit picks power-on or manual
// RQ6: chip reset held for 512 clocks
// RQ7: external reset wins, clears watchdog flag
// RQ8: interval mode requests interrupt each overflow
// RQ9: interval overflow sets its flag with interrupt
// RQ10: watchdog overflow sets watchdog flag
// RQ11: standby refused while timer runs
// RQ12: software picks divider covering oscillator settling
// RQ13: nmi wakes, counter wrap ends standby
// RQ14: counter write beats coincident increment
// RQ15: stop timer before changing divider
// RQ16: stop timer before switching modes
// RQ17: no chip reset: counter and control reset
// RQ18: keyed word writes select counter or control
// RQ19: keyed writes clear flag or load bits
// RQ20: reset control survives watchdog reset only
// RQ21: interval overflow never sets watchdog flag
// RQ22: overflow output idles high
module wit_watchdog_interval_timer (
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic external_reset_n_i,
    // register writes
    input wire logic wr_i,
    input wire logic wr_sel_rst_i,
    input wire logic wr_word_i,
    input wire logic [15:0] wr_data_i,
    // register contents
    output logic [7:0] up_counter_o,
    output logic [7:0] timer_ctrl_status_o,
    output logic [7:0] reset_ctrl_status_o,
    // power control
    input wire logic standby_req_i,
    input wire logic nmi_i,
    output logic standby_o,
    // events
    output logic overflow_out_n_o,
    output logic chip_reset_o,
    output logic chip_reset_manual_o,
    output logic interval_interrupt_o
);
    logic [7:0] cnt_q, cnt_d;
    logic ovf_flag_q, ovf_flag_d;
    logic wt_q, wt_d, tme_q, tme_d;
    logic [2:0] cks_q, cks_d;
    logic watchdog_overflow_flag_q, watchdog_overflow_flag_d, chip_reset_enable_q, chip_reset_enable_d, reset_kind_select_q, reset_kind_select_d;
    logic [wit_pkg::PRE_W-1:0] pre_q, pre_d, pre_mask;
    logic [7:0] ovf_cnt_q, ovf_cnt_d;
    logic [9:0] rst_cnt_q, rst_cnt_d;
    logic ovf_n_q, chip_rst_q, manual_q, irq_q;
    wit_pkg::wit_pwr_t pwr_q, pwr_d;

    wire ext_rst = rst_i || !external_reset_n_i;
    wire key_cnt = wr_i && wr_word_i && (wr_data_i[15:8] == wit_pkg::KEY_CNT);
    wire key_csr = wr_i && wr_word_i && (wr_data_i[15:8] == wit_pkg::KEY_CSR);
    wire wr_cnt = key_cnt && !wr_sel_rst_i; // [RQ18]
    wire wr_csr = key_csr && !wr_sel_rst_i; // [RQ18]
    wire wr_rcs_bits = key_cnt && wr_sel_rst_i; // [RQ19]
    wire wr_watchdog_overflow_flag_clr = key_csr && wr_sel_rst_i && (wr_data_i[7:0] == wit_pkg::WATCHDOG_OVERFLOW_FLAG_CLR_DATA); // [RQ19]
    wire waking = (pwr_q == wit_pkg::WIT_WAKE);
    wire counting = (tme_q && pwr_q == wit_pkg::WIT_RUN) || waking; // [RQ1] [RQ8]
    assign pre_mask = (wit_pkg::PRE_W)'((14'h1 << wit_pkg::DIV_LOG2[cks_q]) - 14'h1);
    wire tick = counting && ((pre_q & pre_mask) == pre_mask);
    wire wrap = tick && !wr_cnt && (cnt_q == wit_pkg::CNT_MAX);
    wire wd_ovf = wrap && !waking && wt_q; // [RQ1]
    wire it_ovf = wrap && !waking && !wt_q; // [RQ8]
    wire wd_clear = wd_ovf; // [RQ17]
    wire enter_sb = standby_req_i && !tme_q && pwr_q == wit_pkg::WIT_RUN; // [RQ11]

    // power state
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            wit_pkg::WIT_RUN: if (enter_sb) pwr_d = wit_pkg::WIT_STANDBY;
            wit_pkg::WIT_STANDBY: if (nmi_i) pwr_d = wit_pkg::WIT_WAKE; // [RQ13]
            wit_pkg::WIT_WAKE: if (wrap) pwr_d = wit_pkg::WIT_RUN; // [RQ13]
            default: pwr_d = wit_pkg::WIT_RUN;
        endcase
    end

    // counter, prescaler and control
    always_comb begin
        pre_d = counting ? pre_q + 1'b1 : '0;
        if (pwr_q == wit_pkg::WIT_STANDBY) pre_d = '0;
        cnt_d = cnt_q;
        if (pwr_q == wit_pkg::WIT_STANDBY) cnt_d = wit_pkg::CNT_RESET;
        else if (wr_cnt) cnt_d = wr_data_i[7:0]; // [RQ14]
        else if (wd_clear) cnt_d = wit_pkg::CNT_RESET; // [RQ17]
        else if (tick) cnt_d = cnt_q + 8'h01;
        ovf_flag_d = ovf_flag_q;
        wt_d = wt_q;
        tme_d = tme_q;
        cks_d = cks_q;
        if (wr_csr) begin
            wt_d = wr_data_i[wit_pkg::CSR_WT];
            tme_d = wr_data_i[wit_pkg::CSR_TME];
            cks_d = wr_data_i[2:0];
            if (!wr_data_i[wit_pkg::CSR_OVF]) ovf_flag_d = 1'b0;
        end
        if (it_ovf) ovf_flag_d = 1'b1; // [RQ9]
        if (wd_clear) begin
            ovf_flag_d = wit_pkg::CSR_RESET[wit_pkg::CSR_OVF]; // [RQ17]
            wt_d = wit_pkg::CSR_RESET[wit_pkg::CSR_WT];
            tme_d = wit_pkg::CSR_RESET[wit_pkg::CSR_TME];
            cks_d = wit_pkg::CSR_RESET[2:0];
        end
        watchdog_overflow_flag_d = watchdog_overflow_flag_q;
        chip_reset_enable_d = chip_reset_enable_q;
        reset_kind_select_d = reset_kind_select_q;
        if (wr_watchdog_overflow_flag_clr) watchdog_overflow_flag_d = 1'b0;
        if (wr_rcs_bits) begin
            chip_reset_enable_d = wr_data_i[wit_pkg::RCS_CHIP_RESET_ENABLE];
            reset_kind_select_d = wr_data_i[wit_pkg::RCS_RESET_KIND_SELECT];
        end
        if (wd_ovf) watchdog_overflow_flag_d = 1'b1; // [RQ10] [RQ21]
        if (pwr_q == wit_pkg::WIT_STANDBY) begin
            watchdog_overflow_flag_d = 1'b0; // [RQ20]
            chip_reset_enable_d = 1'b0;
            reset_kind_select_d = 1'b0;
        end
        ovf_cnt_d = wd_ovf ? wit_pkg::OVF_CYCLES : (ovf_cnt_q != 8'h00 ? ovf_cnt_q - 8'h01 : 8'h00); // [RQ3]
        rst_cnt_d = (wd_ovf && chip_reset_enable_q) ? wit_pkg::RST_CYCLES : // [RQ4] [RQ6]
                    (rst_cnt_q != 10'h000 ? rst_cnt_q - 10'h001 : 10'h000);
    end

    always_ff @(posedge clk_i) begin
        if (ext_rst) begin // [RQ7]
            pwr_q <= wit_pkg::WIT_RUN;
            pre_q <= '0;
            cnt_q <= wit_pkg::CNT_RESET;
            ovf_flag_q <= wit_pkg::CSR_RESET[wit_pkg::CSR_OVF];
            wt_q <= wit_pkg::CSR_RESET[wit_pkg::CSR_WT];
            tme_q <= wit_pkg::CSR_RESET[wit_pkg::CSR_TME];
            cks_q <= wit_pkg::CSR_RESET[2:0];
            watchdog_overflow_flag_q <= wit_pkg::RCS_RESERVED[wit_pkg::RCS_WATCHDOG_OVERFLOW_FLAG]; // [RQ7] [RQ20]
            chip_reset_enable_q <= wit_pkg::RCS_RESERVED[wit_pkg::RCS_CHIP_RESET_ENABLE];
            reset_kind_select_q <= wit_pkg::RCS_RESERVED[wit_pkg::RCS_RESET_KIND_SELECT];
            ovf_cnt_q <= 8'h00;
            rst_cnt_q <= 10'h000;
            ovf_n_q <= 1'b1;
            chip_rst_q <= 1'b0;
            manual_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            ovf_flag_q <= ovf_flag_d;
            wt_q <= wt_d;
            tme_q <= tme_d;
            cks_q <= cks_d;
            watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
            chip_reset_enable_q <= chip_reset_enable_d;
            reset_kind_select_q <= reset_kind_select_d;
            ovf_cnt_q <= ovf_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            ovf_n_q <= (ovf_cnt_d == 8'h00); // [RQ22]
            chip_rst_q <= (rst_cnt_d != 10'h000);
            manual_q <= (wd_ovf && chip_reset_enable_q) ? reset_kind_select_q : manual_q; // [RQ5]
            irq_q <= it_ovf; // [RQ8]
        end
    end

    assign up_counter_o = cnt_q;
    assign timer_ctrl_status_o = wit_pkg::CSR_RESERVED | {ovf_flag_q, wt_q, tme_q, 2'b00, cks_q};
    assign reset_ctrl_status_o = wit_pkg::RCS_RESERVED | {watchdog_overflow_flag_q, chip_reset_enable_q, reset_kind_select_q, 5'h00};
    assign standby_o = (pwr_q != wit_pkg::WIT_RUN);
    assign overflow_out_n_o = ovf_n_q;
    assign chip_reset_o = chip_rst_q;
    assign chip_reset_manual_o = manual_q;
    assign interval_interrupt_o = irq_q;

    a_ovf_low_len: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ3]
        $rose(wd_ovf) |=> !overflow_out_n_o [*8]) else $error("overflow output not held low");
    a_ovf_ends: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ3]
        (ovf_cnt_q == 8'h01 && !wd_ovf) |=> overflow_out_n_o) else $error("overflow output too long");
    a_rst_same_cycle: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ4]
        (wd_ovf && chip_reset_enable_q) |=> (chip_reset_o && !overflow_out_n_o)) else $error("chip reset not simultaneous");
    a_rst_kind: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ5]
        (wd_ovf && chip_reset_enable_q) |=> (chip_reset_manual_o == $past(reset_kind_select_q))) else $error("wrong reset kind");
    a_rst_len: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ6]
        (rst_cnt_q == 10'h001 && !(wd_ovf && chip_reset_enable_q)) |=> !chip_reset_o) else $error("chip reset too long");
    a_ext_wins: assert property (@(posedge clk_i) // [RQ7]
        !external_reset_n_i |=> (!reset_ctrl_status_o[wit_pkg::RCS_WATCHDOG_OVERFLOW_FLAG] && overflow_out_n_o))
        else $error("external reset did not win");
    a_irq_flag: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ8] [RQ9]
        it_ovf |=> (interval_interrupt_o && timer_ctrl_status_o[wit_pkg::CSR_OVF])) else $error("interval event lost");
    a_watchdog_overflow_flag_set: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ10]
        wd_ovf |=> reset_ctrl_status_o[wit_pkg::RCS_WATCHDOG_OVERFLOW_FLAG]) else $error("watchdog flag not set");
    a_no_watchdog_overflow_flag_it: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ21]
        (it_ovf && !watchdog_overflow_flag_q) |=> !reset_ctrl_status_o[wit_pkg::RCS_WATCHDOG_OVERFLOW_FLAG]) else $error("flag set in interval mode");
    a_sb_refused: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ11]
        (!standby_o && tme_q) |=> !standby_o) else $error("standby entered while running");
    a_wake_end: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ13]
        (waking && wrap) |=> (!standby_o && up_counter_o == 8'h00)) else $error("standby not ended");
    a_write_wins: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ14]
        (wr_cnt && !standby_o) |=> (up_counter_o == $past(wr_data_i[7:0]))) else $error("write lost to increment");
    a_wd_clear: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ17]
        (wd_ovf && !wr_cnt && !wr_csr) |=> (up_counter_o == 8'h00 && !timer_ctrl_status_o[wit_pkg::CSR_TME]))
        else $error("timer not reset on overflow");
    a_ovf_idle: assert property (@(posedge clk_i) // [RQ22]
        (ext_rst || (ovf_cnt_q == 8'h00 && !wd_ovf)) |=> overflow_out_n_o)
        else $error("overflow output not idle high");
    a_sb_cleared: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ13] [RQ20]
        (pwr_q == wit_pkg::WIT_STANDBY) |=>
            (up_counter_o == wit_pkg::CNT_RESET && reset_ctrl_status_o == wit_pkg::RCS_RESERVED))
        else $error("standby did not clear counter or reset control");
    a_rcs_keep: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ18] [RQ20]
        (!wr_watchdog_overflow_flag_clr && !wr_rcs_bits && !wd_ovf && pwr_q == wit_pkg::WIT_RUN) |=> $stable(reset_ctrl_status_o))
        else $error("reset control changed without a keyed write");
    a_cnt_keep: assert property (@(posedge clk_i) disable iff (ext_rst) // [RQ18]
        (!wr_cnt && !tick && pwr_q == wit_pkg::WIT_RUN) |=> $stable(up_counter_o))
        else $error("counter changed without write or tick");
endmodule
`default_nettype wire

/* wit_pkg.sv */
package wit_pkg;
    // keyed word writes
    localparam logic [7:0] KEY_CNT = 8'h5a;
    localparam logic [7:0] KEY_CSR = 8'ha5;
    localparam logic [7:0] WATCHDOG_OVERFLOW_FLAG_CLR_DATA = 8'h00;
    // timer_ctrl_status layout
    localparam int CSR_OVF = 7;
    localparam int CSR_WT = 6;
    localparam int CSR_TME = 5;
    localparam logic [7:0] CSR_RESERVED = 8'h18;
    localparam logic [7:0] CSR_RESET = 8'h18;
    // reset_ctrl_status layout
    localparam int RCS_WATCHDOG_OVERFLOW_FLAG = 7;
    localparam int RCS_CHIP_RESET_ENABLE = 6;
    localparam int RCS_RESET_KIND_SELECT = 5;
    localparam logic [7:0] RCS_RESERVED = 8'h1f;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // pulse lengths in system clocks
    localparam logic [7:0] OVF_CYCLES = 8'd128;
    localparam logic [9:0] RST_CYCLES = 10'd512;
    // prescaler: log2 of each divider selection
    localparam int PRE_W = 13;
    localparam logic [3:0] DIV_LOG2 [0:7] = '{4'd1, 4'd6, 4'd7, 4'd8, 4'd9, 4'd10, 4'd12, 4'd13};
    typedef enum logic [1:0] {
        WIT_RUN = 2'b00,
        WIT_STANDBY = 2'b01,
        WIT_WAKE = 2'b11
    } wit_pwr_t;
endpackage

/* wit_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wit_cpu_model (
    // clock
    input wire logic clk_i,
    // keyed writes
    output var logic wr_o,
    output var logic wr_sel_rst_o,
    output var logic wr_word_o,
    output var logic [15:0] wr_data_o,
    // pins
    output var logic external_reset_n_o,
    output var logic standby_req_o,
    output var logic nmi_o
);
    initial begin
        wr_o = 1'b0;
        wr_sel_rst_o = 1'b0;
        wr_word_o = 1'b0;
        wr_data_o = 16'h0000;
        external_reset_n_o = 1'b1;
        standby_req_o = 1'b0;
        nmi_o = 1'b0;
    end
    // one keyed write, key in upper byte
    task wr(input logic sel, input logic word, input logic [15:0] data, input logic hold);
        wr_o = 1'b1;
        wr_sel_rst_o = sel;
        wr_word_o = word;
        wr_data_o = data;
        @(posedge clk_i);
        #1;
        if (!hold) begin
            wr_o = 1'b0;
            wr_data_o = ~data;
        end
    endtask
    task pwr(input logic req, input logic nmi);
        standby_req_o = req;
        nmi_o = nmi;
    endtask
    task ext_reset;
        external_reset_n_o = 1'b0;
        @(posedge clk_i);
        #1;
        external_reset_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr, sel, word, ext_n, sby_req, nmi, sby, ovf_n, crst, cman, irq;
    logic [15:0] wdata;
    logic [7:0] cnt, csr, rcs;
    int failures = 0;
    int compares = 0;
    int n_low, n_rst, i;
    logic [41:0] rows [7] = '{{2'b01, 16'h5a37, 24'h37181f}, {2'b00, 16'h5a55, 24'h37181f},
        {2'b01, 16'h3c11, 24'h37181f}, {2'b01, 16'ha507, 24'h371f1f}, {2'b11, 16'h5a60, 24'h371f7f},
        {2'b11, 16'ha501, 24'h371f7f}, {2'b11, 16'h5a00, 24'h371f1f}};
    always #2 clk_i = ~clk_i;
    wit_cpu_model cpu (.clk_i(clk_i), .wr_o(wr), .wr_sel_rst_o(sel), .wr_word_o(word), .wr_data_o(wdata),
        .external_reset_n_o(ext_n), .standby_req_o(sby_req), .nmi_o(nmi));
    wit_watchdog_interval_timer dut (.clk_i(clk_i), .rst_i(rst_i), .external_reset_n_i(ext_n), .wr_i(wr),
        .wr_sel_rst_i(sel), .wr_word_i(word), .wr_data_i(wdata), .up_counter_o(cnt), .timer_ctrl_status_o(csr),
        .reset_ctrl_status_o(rcs), .standby_req_i(sby_req), .nmi_i(nmi), .standby_o(sby),
        .overflow_out_n_o(ovf_n), .chip_reset_o(crst), .chip_reset_manual_o(cman), .interval_interrupt_o(irq));
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task chkn(input int got, input int exp);
        compares++;
        if (got != exp) begin
            failures++;
            $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    task finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task wdog(input logic [7:0] rd, input logic ext);
        cpu.wr(1'b1, 1'b1, {8'h5a, rd}, 1'b1);
        cpu.wr(1'b0, 1'b1, 16'h5afe, 1'b1);
        cpu.wr(1'b0, 1'b1, 16'ha560, 1'b0);
        for (i = 0; i < 50 && ovf_n === 1'b1; i++) step(1);
        chk1(ovf_n, 1'b0);
        chk8(rcs, {1'b1, rd[6:5], 5'h1f});
        chk8(cnt, 8'h00);
        chk8(csr, 8'h18);
        chk1(crst, rd[6]);
        if (rd[6]) chk1(cman, rd[5]);
        if (ext) begin
            cpu.ext_reset();
            chk1(ovf_n, 1'b1);
            chk8(rcs, 8'h1f);
            chk1(crst, 1'b0);
        end else begin
            n_low = 1;
            n_rst = rd[6];
            for (i = 0; i < 600; i++) begin
                step(1);
                n_low += (ovf_n === 1'b0);
                n_rst += (crst === 1'b1);
            end
            chkn(n_low, 128);
            chkn(n_rst, rd[6] ? 512 : 0);
            chk8(rcs, {1'b1, rd[6:5], 5'h1f});
            cpu.wr(1'b1, 1'b1, 16'ha500, 1'b0);
            chk8(rcs, {1'b0, rd[6:5], 5'h1f});
            step(1);
        end
        done("watchdog");
    endtask
    initial begin
        step(2);
        chk8(cnt, 8'h00);
        chk8(csr, 8'h18);
        chk8(rcs, 8'h1f);
        chk1(ovf_n, 1'b1);
        chk1(crst | sby | irq, 1'b0);
        rst_i = 1'b0;
        done("reset");
        foreach (rows[k]) begin
            cpu.wr(rows[k][41], rows[k][40], rows[k][39:24], 1'b0);
            chk8(cnt, rows[k][23:16]);
            chk8(csr, rows[k][15:8]);
            chk8(rcs, rows[k][7:0]);
            step(1);
        end
        done("keys");
        wdog(8'h60, 1'b0);
        wdog(8'h00, 1'b0);
        wdog(8'h40, 1'b1);
        cpu.wr(1'b0, 1'b1, 16'h5afe, 1'b1);
        cpu.wr(1'b0, 1'b1, 16'ha520, 1'b0);
        for (i = 0; i < 50 && irq !== 1'b1; i++) step(1);
        chk1(irq, 1'b1);
        chk8(csr, 8'hb8);
        chk8(rcs, 8'h1f);
        step(1);
        chk1(irq, 1'b0);
        cpu.wr(1'b0, 1'b1, 16'h5a40, 1'b1);
        chk8(cnt, 8'h40);
        cpu.wr(1'b0, 1'b1, 16'h5a40, 1'b0);
        chk8(cnt, 8'h40);
        done("interval");
        cpu.pwr(1'b1, 1'b0);
        step(3);
        chk1(sby, 1'b0);
        cpu.wr(1'b1, 1'b1, 16'h5a60, 1'b1);
        cpu.wr(1'b0, 1'b1, 16'ha501, 1'b0);
        step(1);
        chk1(sby, 1'b1);
        step(1);
        chk8(rcs, 8'h1f);
        chk8(cnt, 8'h00);
        cpu.pwr(1'b0, 1'b1);
        step(1);
        cpu.pwr(1'b0, 1'b0);
        for (i = 0; i < 20000 && sby === 1'b1; i++) step(1);
        chk1(sby, 1'b0);
        chkn(i, 256 << wit_pkg::DIV_LOG2[1]);
        done("standby");
        finish_test();
    end
    initial begin
        #200000;
        failures++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
    end
endmodule
`default_nettype wire
